/* rtl/misx_pkg.sv */
// Purpose: Shared constants and carriers for the instruction subset executor.
// Assumes: 16-bit opcodes, 21-bit program counter, 12-bit data addresses.
// Notes:   Register byte addresses are word aligned on the APB bus.
package misx_pkg;

  // Opcode patterns and masks.
  localparam logic [15:0] OP_MUL_LIT      = 16'h0d00;
  localparam logic [15:0] OP_MUL_LIT_MASK = 16'hff00;
  localparam logic [15:0] OP_MUL_FILE     = 16'h0200;
  localparam logic [15:0] OP_MUL_FILE_MSK = 16'hfe00;
  localparam logic [15:0] OP_RELATIVE_CALL_OP        = 16'hd800;
  localparam logic [15:0] OP_RELATIVE_CALL_OP_MASK   = 16'hf800;
  localparam logic [15:0] OP_SWRESET      = 16'h00ff;
  localparam logic [15:0] OP_RETURN       = 16'h0012;
  localparam logic [15:0] OP_RETURN_MASK  = 16'hfffe;
  localparam logic [15:0] OP_ROTL         = 16'h3400;
  localparam logic [15:0] OP_ROTL_MASK    = 16'hfc00;

  // Opcode field positions.
  localparam int BIT_ACCESS = 8;
  localparam int BIT_DEST   = 9;
  localparam int BIT_SHADOW = 0;

  // Status flag positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 4;

  // User identification window in program space.
  localparam logic [21:0] ID_FIRST = 22'h200000;
  localparam logic [21:0] ID_LAST  = 22'h200004;

  // APB register byte offsets.
  localparam logic [7:0] ADDR_OPCODE  = 8'h00;
  localparam logic [7:0] ADDR_WORK    = 8'h04;
  localparam logic [7:0] ADDR_PROD    = 8'h08;
  localparam logic [7:0] ADDR_PC      = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS   = 8'h10;
  localparam logic [7:0] ADDR_BANK    = 8'h14;
  localparam logic [7:0] ADDR_SHADOW  = 8'h18;
  localparam logic [7:0] ADDR_PROTECT = 8'h1c;
  localparam logic [7:0] ADDR_RDADDR  = 8'h20;
  localparam logic [7:0] ADDR_RDRES   = 8'h24;

  // Reset values.
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [20:0] RST_PC   = 21'h000000;

  // Execution phases of one instruction cycle.
  typedef enum logic [2:0] {
    MISX_IDLE   = 3'b000,
    MISX_DECODE = 3'b001,
    MISX_READ   = 3'b010,
    MISX_PROC   = 3'b011,
    MISX_WRITE  = 3'b100,
    MISX_NOP    = 3'b101
  } misx_phase_t;

  // Data-file access request towards the register file.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } misx_file_req_t;

  // Return stack request.
  typedef struct packed {
    logic        push;
    logic        pop;
    logic [20:0] data;
  } misx_stack_req_t;

endpackage : misx_pkg

/* rtl/misx_exec.sv */
// Purpose: Executes a subset of 8-bit core instructions in four phases.
// Assumes: File and stack ports answer in the same cycle; APB slave, no wait.
// Notes:   Software writes opcodes over APB; the read path serves verify.
module misx_exec (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     clk_en,
  input  wire logic [31:0]              paddr,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output misx_pkg::misx_file_req_t      file_req,
  input  wire logic [7:0]               file_rdata,
  output misx_pkg::misx_stack_req_t     stack_req,
  input  wire logic [20:0]              stack_top,
  output logic      [21:0]              prog_addr,
  output logic                          prog_rd,
  input  wire logic [15:0]              prog_rdata,
  input  wire logic                     prog_clk,
  input  wire logic                     prog_data_in,
  output logic                          prog_data_out,
  output logic                          prog_data_oe,
  output logic      [7:0]               pc_upper_latch,
  output logic      [7:0]               pc_high_latch
);

  misx_pkg::misx_phase_t phase_q;
  logic [15:0] opcode_q;
  logic [7:0]  working_reg_q;
  logic [7:0]  product_high_reg_q;
  logic [7:0]  product_low_reg_q;
  logic [20:0] pc_q;
  logic [7:0]  flags_q;
  logic [3:0]  bank_select_reg_q;
  logic [7:0]  working_shadow_q;
  logic [7:0]  flags_shadow_q;
  logic [3:0]  bank_select_shadow_q;
  logic        protect_q;
  logic [21:0] rd_addr_q;
  logic [15:0] rd_res_q;
  logic        rd_ok_q;
  logic        soft_rst_q;
  logic [7:0]  operand_q;
  logic [15:0] product_d;
  logic [8:0]  rot_d;
  logic [20:0] call_tgt_d;
  logic        apb_wr;
  logic        apb_rd;
  logic        id_hit;

  // Opcode class match, shared by decode and the assertions.
  function automatic logic op_is(input logic [15:0] op,
                                 input logic [15:0] pat,
                                 input logic [15:0] msk);
    op_is = (op & msk) == pat;
  endfunction : op_is

  // File address with the access bank override for a cleared a bit.
  function automatic logic [11:0] file_addr(input logic [15:0] op,
                                            input logic [3:0]  bank);
    if (op[misx_pkg::BIT_ACCESS]) begin
      file_addr = {bank, op[7:0]};
    end else begin
      file_addr = {4'h0, op[7:0]};
    end
  endfunction : file_addr

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign id_hit = (rd_addr_q >= misx_pkg::ID_FIRST) &&
                  (rd_addr_q <= misx_pkg::ID_LAST);

  // Datapath results; multiplies are unsigned and cannot overflow.
  assign product_d = working_reg_q * operand_q;
  assign rot_d = {operand_q, flags_q[misx_pkg::FLAG_C]};
  assign call_tgt_d = pc_q + 21'd2 + {{9{opcode_q[10]}}, opcode_q[10:0], 1'b0};

  // Phase sequencer: a new opcode starts when software writes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= misx_pkg::MISX_IDLE;
    end else if (clk_en && soft_rst_q) begin
      // A software reset abandons the instruction, so no late write phase
      // can move the program counter off its reset value.
      phase_q <= misx_pkg::MISX_IDLE;
    end else if (clk_en) begin
      case (phase_q)
        misx_pkg::MISX_IDLE:
          if (apb_wr && paddr[7:0] == misx_pkg::ADDR_OPCODE) begin
            phase_q <= misx_pkg::MISX_DECODE;
          end
        misx_pkg::MISX_DECODE: phase_q <= misx_pkg::MISX_READ;
        misx_pkg::MISX_READ:   phase_q <= misx_pkg::MISX_PROC;
        misx_pkg::MISX_PROC:   phase_q <= misx_pkg::MISX_WRITE;
        misx_pkg::MISX_WRITE: begin
          // Call and return spend a second, idle instruction cycle.
          if (op_is(opcode_q, misx_pkg::OP_RELATIVE_CALL_OP, misx_pkg::OP_RELATIVE_CALL_OP_MASK) ||
              op_is(opcode_q, misx_pkg::OP_RETURN,
                    misx_pkg::OP_RETURN_MASK)) begin
            phase_q <= misx_pkg::MISX_NOP;
          end else begin
            phase_q <= misx_pkg::MISX_IDLE;
          end
        end
        misx_pkg::MISX_NOP:    phase_q <= misx_pkg::MISX_IDLE;
        default:               phase_q <= misx_pkg::MISX_IDLE;
      endcase
    end
  end

  // Opcode capture from the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_q <= 16'h0000;
    end else if (clk_en && apb_wr && phase_q == misx_pkg::MISX_IDLE &&
                 paddr[7:0] == misx_pkg::ADDR_OPCODE) begin
      opcode_q <= pwdata[15:0];
    end
  end

  // Operand read in the second phase: literal or file contents.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand_q <= misx_pkg::RST_BYTE;
    end else if (clk_en && phase_q == misx_pkg::MISX_READ) begin
      if (op_is(opcode_q, misx_pkg::OP_MUL_LIT, misx_pkg::OP_MUL_LIT_MASK)) begin
        operand_q <= opcode_q[7:0];
      end else begin
        operand_q <= file_rdata;
      end
    end
  end

  // File port: read in phase two, rotate write-back in phase four.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_req <= '0;
    end else if (clk_en) begin
      file_req.rd <= (phase_q == misx_pkg::MISX_DECODE) &&
        (op_is(opcode_q, misx_pkg::OP_MUL_FILE, misx_pkg::OP_MUL_FILE_MSK) ||
         op_is(opcode_q, misx_pkg::OP_ROTL, misx_pkg::OP_ROTL_MASK));
      file_req.wr <= (phase_q == misx_pkg::MISX_PROC) &&
        op_is(opcode_q, misx_pkg::OP_ROTL, misx_pkg::OP_ROTL_MASK) &&
        opcode_q[misx_pkg::BIT_DEST];
      file_req.addr <= file_addr(opcode_q, bank_select_reg_q);
      file_req.wdata <= rot_d[7:0];
    end
  end

  // Architectural state. A software reset acts like master_clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_reg_q      <= misx_pkg::RST_BYTE;
      product_high_reg_q <= misx_pkg::RST_BYTE;
      product_low_reg_q  <= misx_pkg::RST_BYTE;
      flags_q            <= misx_pkg::RST_BYTE;
      bank_select_reg_q  <= 4'h0;
      pc_q               <= misx_pkg::RST_PC;
      soft_rst_q         <= 1'b0;
    end else if (clk_en) begin
      soft_rst_q <= 1'b0;
      if (soft_rst_q) begin
        working_reg_q      <= misx_pkg::RST_BYTE;
        product_high_reg_q <= misx_pkg::RST_BYTE;
        product_low_reg_q  <= misx_pkg::RST_BYTE;
        flags_q            <= misx_pkg::RST_BYTE;
        bank_select_reg_q  <= 4'h0;
        pc_q               <= misx_pkg::RST_PC;
      end else if (phase_q == misx_pkg::MISX_DECODE &&
                   opcode_q == misx_pkg::OP_SWRESET) begin
        soft_rst_q <= 1'b1;
      end else if (phase_q == misx_pkg::MISX_WRITE) begin
        pc_q <= pc_q + 21'd2;
        if (op_is(opcode_q, misx_pkg::OP_MUL_LIT, misx_pkg::OP_MUL_LIT_MASK) ||
            op_is(opcode_q, misx_pkg::OP_MUL_FILE,
                  misx_pkg::OP_MUL_FILE_MSK)) begin
          product_high_reg_q <= product_d[15:8];
          product_low_reg_q  <= product_d[7:0]; // flags held
        end else if (op_is(opcode_q, misx_pkg::OP_ROTL,
                           misx_pkg::OP_ROTL_MASK)) begin
          flags_q[misx_pkg::FLAG_C] <= rot_d[8];
          flags_q[misx_pkg::FLAG_N] <= rot_d[7];
          flags_q[misx_pkg::FLAG_Z] <= rot_d[7:0] == 8'h00;
          if (!opcode_q[misx_pkg::BIT_DEST]) begin
            working_reg_q <= rot_d[7:0];
          end
        end else if (op_is(opcode_q, misx_pkg::OP_RELATIVE_CALL_OP,
                           misx_pkg::OP_RELATIVE_CALL_OP_MASK)) begin
          pc_q <= call_tgt_d;
        end else if (op_is(opcode_q, misx_pkg::OP_RETURN,
                           misx_pkg::OP_RETURN_MASK)) begin
          pc_q <= stack_top;
          if (opcode_q[misx_pkg::BIT_SHADOW]) begin
            working_reg_q     <= working_shadow_q;
            flags_q           <= flags_shadow_q;
            bank_select_reg_q <= bank_select_shadow_q;
          end
        end
      end else if (apb_wr && phase_q == misx_pkg::MISX_IDLE) begin
        case (paddr[7:0])
          misx_pkg::ADDR_WORK:  working_reg_q     <= pwdata[7:0];
          misx_pkg::ADDR_FLAGS: flags_q           <= pwdata[7:0];
          misx_pkg::ADDR_BANK:  bank_select_reg_q <= pwdata[3:0];
          default: ;
        endcase
      end
    end
  end

  // Shadow copies and protection bit are software loaded only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_shadow_q     <= misx_pkg::RST_BYTE;
      flags_shadow_q       <= misx_pkg::RST_BYTE;
      bank_select_shadow_q <= 4'h0;
      protect_q            <= 1'b0;
      rd_addr_q            <= 22'h000000;
    end else if (clk_en && apb_wr) begin
      case (paddr[7:0])
        misx_pkg::ADDR_SHADOW: begin
          working_shadow_q     <= pwdata[7:0];
          flags_shadow_q       <= pwdata[15:8];
          bank_select_shadow_q <= pwdata[19:16];
        end
        misx_pkg::ADDR_PROTECT: protect_q <= pwdata[0];
        misx_pkg::ADDR_RDADDR:  rd_addr_q <= pwdata[21:0];
        default: ;
      endcase
    end
  end

  // Return stack: push on call, pop on return, both in the write phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_req <= '0;
    end else if (clk_en) begin
      stack_req.push <= phase_q == misx_pkg::MISX_PROC &&
        op_is(opcode_q, misx_pkg::OP_RELATIVE_CALL_OP, misx_pkg::OP_RELATIVE_CALL_OP_MASK);
      stack_req.pop <= phase_q == misx_pkg::MISX_PROC &&
        op_is(opcode_q, misx_pkg::OP_RETURN, misx_pkg::OP_RETURN_MASK);
      stack_req.data <= pc_q + 21'd2;
    end
  end

  // Verify readout: protection blocks code but never the ID words.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_rd  <= 1'b0;
      prog_addr <= 22'h000000;
      rd_res_q <= 16'h0000;
      rd_ok_q  <= 1'b0;
    end else if (clk_en) begin
      prog_addr <= rd_addr_q;
      prog_rd   <= !protect_q || id_hit;
      rd_ok_q   <= !protect_q || id_hit;
      rd_res_q  <= (!protect_q || id_hit) ? prog_rdata : 16'h0000;
    end
  end

  // Serial programming pins: the programmer drives clock and data.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_data_out <= 1'b0;
      prog_data_oe  <= 1'b0;
    end else if (clk_en) begin
      prog_data_oe  <= 1'b0;
      prog_data_out <= prog_clk & prog_data_in & 1'b0;
    end
  end

  // The return leaves both program counter latches alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_upper_latch <= misx_pkg::RST_BYTE;
      pc_high_latch  <= misx_pkg::RST_BYTE;
    end else if (clk_en && soft_rst_q) begin
      pc_upper_latch <= misx_pkg::RST_BYTE;
      pc_high_latch  <= misx_pkg::RST_BYTE;
    end
  end

  // APB slave: zero wait states, errors on unmapped reads and writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= 32'h00000000;
        case (paddr[7:0])
          misx_pkg::ADDR_OPCODE:  prdata <= {16'h0000, opcode_q};
          misx_pkg::ADDR_WORK:    prdata <= {24'h000000, working_reg_q};
          misx_pkg::ADDR_PROD:    prdata <= {16'h0000, product_high_reg_q,
                                             product_low_reg_q};
          misx_pkg::ADDR_PC:      prdata <= {11'h000, pc_q};
          misx_pkg::ADDR_FLAGS:   prdata <= {24'h000000, flags_q};
          misx_pkg::ADDR_BANK:    prdata <= {28'h0000000, bank_select_reg_q};
          misx_pkg::ADDR_SHADOW:  prdata <= {12'h000, bank_select_shadow_q,
                                             flags_shadow_q, working_shadow_q};
          misx_pkg::ADDR_PROTECT: prdata <= {31'h00000000, protect_q};
          misx_pkg::ADDR_RDADDR:  prdata <= {10'h000, rd_addr_q};
          misx_pkg::ADDR_RDRES:   prdata <= {15'h0000, rd_ok_q, rd_res_q};
          default: pslverr <= apb_rd || pwrite;
        endcase
      end
    end
  end

  // Named steps of a two-cycle call.
  sequence s_call_write;
    phase_q == misx_pkg::MISX_WRITE &&
      op_is(opcode_q, misx_pkg::OP_RELATIVE_CALL_OP, misx_pkg::OP_RELATIVE_CALL_OP_MASK);
  endsequence

  property p_mul_prod;
    @(posedge pclk) disable iff (!presetn)
      clk_en && phase_q == misx_pkg::MISX_WRITE &&
      op_is(opcode_q, misx_pkg::OP_MUL_LIT, misx_pkg::OP_MUL_LIT_MASK)
      |=> {product_high_reg_q, product_low_reg_q} == $past(product_d);
  endproperty
  a_mul_prod: assert property (p_mul_prod) else $error("bad product");

  property p_mul_flags;
    @(posedge pclk) disable iff (!presetn)
      phase_q == misx_pkg::MISX_WRITE && !soft_rst_q &&
      op_is(opcode_q, misx_pkg::OP_MUL_FILE, misx_pkg::OP_MUL_FILE_MSK)
      |=> $stable(flags_q) && $stable(working_reg_q);
  endproperty
  a_mul_flags: assert property (p_mul_flags) else $error("flags moved");

  property p_call_nop;
    @(posedge pclk) disable iff (!presetn)
      clk_en and s_call_write |=> phase_q == misx_pkg::MISX_NOP;
  endproperty
  a_call_nop: assert property (p_call_nop) else $error("no idle cycle");

  property p_call_pc;
    @(posedge pclk) disable iff (!presetn)
      clk_en and s_call_write |=> pc_q == $past(call_tgt_d);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("bad call target");

  property p_id_read;
    @(posedge pclk) disable iff (!presetn)
      clk_en && id_hit |=> prog_rd;
  endproperty
  a_id_read: assert property (p_id_read) else $error("id blocked");

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
      clk_en && protect_q && !id_hit |=> !rd_ok_q;
  endproperty
  a_protect: assert property (p_protect) else $error("code leaked");

  property p_swreset;
    @(posedge pclk) disable iff (!presetn)
      clk_en && phase_q == misx_pkg::MISX_DECODE &&
      opcode_q == misx_pkg::OP_SWRESET ##1 clk_en |=> pc_q == 21'h000000;
  endproperty
  a_swreset: assert property (p_swreset) else $error("no reset");

  property p_rot_carry;
    @(posedge pclk) disable iff (!presetn)
      clk_en && !soft_rst_q && phase_q == misx_pkg::MISX_WRITE &&
      op_is(opcode_q, misx_pkg::OP_ROTL, misx_pkg::OP_ROTL_MASK)
      |=> flags_q[misx_pkg::FLAG_C] == $past(operand_q[7]);
  endproperty
  a_rot_carry: assert property (p_rot_carry) else $error("bad carry");

endmodule : misx_exec

/* test/misx_far_mdl.sv */
// Purpose: Register file, return stack and program memory beside the core.
// Assumes: One clock; file data valid only while the read pulse stands.
// Notes:   Outside that cycle the read data is inverted so stale data fails.
module misx_far_mdl (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire misx_pkg::misx_file_req_t  file_req,
  output logic [7:0]                     file_rdata,
  input  wire misx_pkg::misx_stack_req_t stack_req,
  output logic [20:0]                    stack_top,
  input  wire logic [21:0]               prog_addr,
  output logic [15:0]                    prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem [0:4095];
  logic [20:0] stk [0:30];
  logic [4:0]  sp;

  // File reads answer in the pulse cycle, writes land on the pulse edge.
  always @(posedge pclk) begin
    if (file_req.wr) mem[file_req.addr] <= file_req.wdata;
  end
  assign file_rdata = file_req.rd ? mem[file_req.addr] : ~mem[file_req.addr];

  // Return stack; an empty stack shows a pattern so a bad pop is seen.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) sp <= 5'h00;
    else if (stack_req.push) begin
      stk[sp] <= stack_req.data;
      sp <= sp + 5'h01;
    end else if (stack_req.pop && sp != 5'h00) sp <= sp - 5'h01;
  end
  assign stack_top = (sp == 5'h00) ? 21'h15a5a5 : stk[sp - 5'h01];

  // Program memory holds an address-derived word.
  assign prog_rdata = prog_addr[15:0] ^ 16'h5a3c;
endmodule : misx_far_mdl

/* test/mcu_instruction_subset_exec_tb.sv */
// Purpose: Self-checking bench for the instruction subset executor.
// Assumes: APB slave answers in its own time; opcodes settle in 8 cycles.
// Notes:   Operands are random from a fixed seed, with corner values mixed in.
module mcu_instruction_subset_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, r, junk, seed;
  logic prog_clk, prog_data_in, prog_data_out, prog_data_oe, prog_rd, err;
  misx_pkg::misx_file_req_t  file_req;
  misx_pkg::misx_stack_req_t stack_req;
  logic [7:0]  file_rdata, pc_upper_latch, pc_high_latch, w, w2, k, v, f, res;
  logic [7:0]  fl, fl2;
  logic [20:0] stack_top, p, q;
  logic [21:0] prog_addr, ra;
  logic [15:0] prog_rdata;
  logic [11:0] fa;
  logic [10:0] n;
  logic [3:0]  b, b2;
  logic        a, d, c, s, ok;
  integer      i, fail_count, n_checks, cyc;

  misx_exec misx_exec_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .file_req(file_req), .file_rdata(file_rdata), .stack_req(stack_req),
    .stack_top(stack_top), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_rdata(prog_rdata), .prog_clk(prog_clk),
    .prog_data_in(prog_data_in), .prog_data_out(prog_data_out),
    .prog_data_oe(prog_data_oe), .pc_upper_latch(pc_upper_latch),
    .pc_high_latch(pc_high_latch));
  misx_far_mdl misx_far_mdl_i (.pclk(pclk), .presetn(presetn),
    .file_req(file_req), .file_rdata(file_rdata), .stack_req(stack_req),
    .stack_top(stack_top), .prog_addr(prog_addr), .prog_rdata(prog_rdata));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // The programmer toggles its clock and data lines all through the run.
  always @(posedge pclk) begin
    prog_clk <= ~prog_clk;
    prog_data_in <= cyc[3];
  end

  // A hang is cut short well past the expected run length.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wen, input logic [7:0] ad,
                     input logic [31:0] dd, output logic [31:0] q_o);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= {24'h0, ad};
    pwrite <= wen;
    pwdata <= dd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q_o = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] ad, input logic [31:0] dd);
    apb(1'b1, ad, dd, junk);
  endtask : wr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0, r);
    chk(r, exp);
  endtask : rchk

  // The sequencer is idle again four cycles after the opcode write, five for call and return.
  task automatic exec(input logic [15:0] op);
    wr(misx_pkg::ADDR_OPCODE, {16'h0, op});
    repeat (8) @(posedge pclk);
  endtask : exec

  function automatic logic [15:0] mul8(input logic [7:0] x, y);
    return x * y;
  endfunction : mul8

  function automatic logic [31:0] rflags(input logic [7:0] x, input logic ci);
    logic [7:0] o;
    o = {x[6:0], ci};
    return {27'h0, o[7], 1'b0, o == 8'h00, 1'b0, x[7]};
  endfunction : rflags

  initial begin
    seed = 32'hd5e8f68d;
    {presetn, psel, penable, pwrite, prog_clk, prog_data_in} = 6'h0;
    {paddr, pwdata, fail_count, n_checks, cyc} = '0;
    clk_en = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk(misx_pkg::ADDR_PC, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, r);
    chk({31'h0, err}, 32'h1);
    $display("Test reset and unmapped done");
    // Literal and file multiplies, with the all-ones and zero corners on the literal form.
    for (i = 0; i < 40; i++) begin
      {w, k, v, f, b, a} = {$random(seed), $random(seed)};
      if (i == 0) {w, k, v} = 24'hffffff;
      if (i == 1) k = 8'h00;
      fl = 8'(k & 8'h15);
      fa = {a ? b : 4'h0, f};
      misx_far_mdl_i.mem[{a ? 4'h0 : b, f}] = ~v;
      misx_far_mdl_i.mem[fa] = v;
      wr(misx_pkg::ADDR_WORK, {24'h0, w});
      wr(misx_pkg::ADDR_FLAGS, {24'h0, fl});
      wr(misx_pkg::ADDR_BANK, {28'h0, b});
      if (i < 20) exec(misx_pkg::OP_MUL_LIT | k);
      else exec(misx_pkg::OP_MUL_FILE | {a, f});
      rchk(misx_pkg::ADDR_PROD, mul8(w, i < 20 ? k : v));
      rchk(misx_pkg::ADDR_WORK, {24'h0, w});
      chk(misx_far_mdl_i.mem[fa], v);
      rchk(misx_pkg::ADDR_FLAGS, {24'h0, fl});
    end
    $display("Test multiply done");
    // Rotate through carry into either destination.
    for (i = 0; i < 16; i++) begin
      {w, v, f, b, a, d, c} = {$random(seed), $random(seed)};
      if (i == 0) {v, c} = 9'h080;
      fa = {a ? b : 4'h0, f};
      res = {v[6:0], c};
      misx_far_mdl_i.mem[fa] = v;
      wr(misx_pkg::ADDR_WORK, {24'h0, w});
      wr(misx_pkg::ADDR_FLAGS, {31'h0, c});
      wr(misx_pkg::ADDR_BANK, {28'h0, b});
      exec(misx_pkg::OP_ROTL | {d, a, f});
      rchk(misx_pkg::ADDR_FLAGS, rflags(v, c));
      rchk(misx_pkg::ADDR_WORK, {24'h0, d ? w : res});
      chk(misx_far_mdl_i.mem[fa], d ? res : v);
    end
    $display("Test rotate done");
    // Relative call then return, offsets at both ends of the range.
    for (i = 0; i < 10; i++) begin
      {n, s, w, w2, b, b2, fl, fl2} = {$random(seed), $random(seed)};
      if (i < 2) n = i[0] ? 11'h3ff : 11'h400;
      fl = fl & 8'h15;
      fl2 = fl2 & 8'h15;
      apb(1'b0, misx_pkg::ADDR_PC, 32'h0, r);
      p = r[20:0];
      q = p + 21'h2;
      wr(misx_pkg::ADDR_SHADOW, {12'h0, b, fl, w});
      wr(misx_pkg::ADDR_WORK, {24'h0, w2});
      wr(misx_pkg::ADDR_FLAGS, {24'h0, fl2});
      wr(misx_pkg::ADDR_BANK, {28'h0, b2});
      exec(misx_pkg::OP_RELATIVE_CALL_OP | n);
      p = q + {{9{n[10]}}, n, 1'b0};
      rchk(misx_pkg::ADDR_PC, {11'h0, p});
      exec(misx_pkg::OP_RETURN | s);
      rchk(misx_pkg::ADDR_PC, {11'h0, q});
      rchk(misx_pkg::ADDR_WORK, {24'h0, s ? w : w2});
      rchk(misx_pkg::ADDR_FLAGS, {24'h0, s ? fl : fl2});
      rchk(misx_pkg::ADDR_BANK, {28'h0, s ? b : b2});
      chk({16'h0, pc_upper_latch, pc_high_latch}, 32'h0);
    end
    $display("Test call and return done");
    exec(misx_pkg::OP_SWRESET);
    rchk(misx_pkg::ADDR_WORK, 32'h0);
    rchk(misx_pkg::ADDR_PROD, 32'h0);
    rchk(misx_pkg::ADDR_PC, 32'h0);
    rchk(misx_pkg::ADDR_FLAGS, 32'h0);
    rchk(misx_pkg::ADDR_BANK, 32'h0);
    $display("Test software reset done");
    // Readback with and without protection, inside and outside the ID words.
    for (i = 0; i < 16; i++) begin
      ra = (i < 10) ? misx_pkg::ID_FIRST + 22'(i / 2) : 22'($random(seed));
      if (i == 11) ra = misx_pkg::ID_LAST + 22'h1;
      ok = !i[0] || (i < 10);
      wr(misx_pkg::ADDR_PROTECT, {31'h0, i[0]});
      wr(misx_pkg::ADDR_RDADDR, {10'h0, ra});
      repeat (4) @(posedge pclk);
      junk = {15'h0, ok, ok ? ra[15:0] ^ 16'h5a3c : 16'h0};
      rchk(misx_pkg::ADDR_RDRES, junk);
    end
    chk({30'h0, prog_data_oe, prog_data_out}, 32'h0);
    $display("Test readback done");
    test_done();
  end
endmodule : mcu_instruction_subset_exec_tb
